// [hdl/fcp_config_port.sv]
`timescale 1ns/1ps
`include "fcp_regs.svh"
// Function
// R1: master serial forwards sampled bit next fall
// R2: speed pin low 10 MHz, high 1.25 MHz
// R3: read clock seven low, one high
// R4: parallel byte shifts out 1.5 clocks later
// R5: host may write once ready rises
// R6: ready on ready pin and bit seven
// R7: read strobe drives bit seven with ready
// R8: slave source waits 1 us after clear
// R9: program release clears memory then raises clear
// R10: host waits 1.5 us after clear
// R11: written byte shifts out from falling edge
// R12: address advances per period, rising sample
module fcp_config_port (
	input wire logic clk,
	input wire logic srst,
	input wire fcp_pkg::fcp_pins_t pinsIn,
	output logic configClock,
	output logic daisyOut,
	output logic readyOut,
	output logic initDone,
	output fcp_pkg::fcp_rom_t romOut,
	output logic dataBitSevenOut,
	output logic dataBitSevenOe,
	output logic cfgBit,
	output logic cfgBitValid
);

	localparam int PW = $bits(fcp_pkg::fcp_pins_t);

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers: a change counts once stages two and three agree
	fcp_pkg::fcp_pins_t s1_ff, s2_ff, s3_ff, pin_ff;
	genvar gi;
	generate
		for (gi = 0; gi < PW; gi++)
		begin : g_sync
			always_ff @(posedge clk)
			begin
				if (srst)
				begin
					s1_ff[gi] <= 1'b1;
					s2_ff[gi] <= 1'b1;
					s3_ff[gi] <= 1'b1;
					pin_ff[gi] <= 1'b1;
				end
				else
				begin
					s1_ff[gi] <= pinsIn[gi];
					s2_ff[gi] <= s1_ff[gi];
					s3_ff[gi] <= s2_ff[gi];
					if (s2_ff[gi] == s3_ff[gi])
						pin_ff[gi] <= s3_ff[gi];
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// sequencing: hold while program requested, clear, then load
	fcp_pkg::fcp_state_t state_ff, nxt_state;
	fcp_pkg::fcp_mode_t mode_ff;
	logic [11:0] clrCnt_ff;
	wire clrDoneW = (clrCnt_ff == 12'(`FCP_INIT_LAT_CYC - 1));
	wire loading = (state_ff == fcp_pkg::ST_LOAD);

	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			fcp_pkg::ST_HOLD: if (pin_ff.programRequestN) nxt_state = fcp_pkg::ST_CLEAR;
			fcp_pkg::ST_CLEAR: if (!pin_ff.programRequestN) nxt_state = fcp_pkg::ST_HOLD;
				else if (clrDoneW) nxt_state = fcp_pkg::ST_LOAD; // R9
			fcp_pkg::ST_LOAD: if (!pin_ff.programRequestN) nxt_state = fcp_pkg::ST_HOLD;
			default: nxt_state = fcp_pkg::ST_HOLD;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			state_ff <= fcp_pkg::ST_HOLD;
			clrCnt_ff <= 12'h000;
			mode_ff <= fcp_pkg::MD_NONE;
		end
		else
		begin
			state_ff <= nxt_state;
			clrCnt_ff <= (state_ff == fcp_pkg::ST_CLEAR) ? clrCnt_ff + 12'h001 : 12'h000; // R9
			// keep sampling through the clear so the synchronisers have settled after reset
			if (state_ff != fcp_pkg::ST_LOAD)
				mode_ff <= fcp_pkg::fcp_mode_t'(pin_ff.modeSel);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// configuration clock divider, period from the speed pin
	logic [5:0] divCnt_ff;
	logic config_clock_ff;
	wire runClk = loading && (mode_ff != fcp_pkg::MD_NONE);
	wire [5:0] periodW = pin_ff.clockSpeedSelect ? 6'(`FCP_CONFIG_CLOCK_SLOW_CYC) : 6'(`FCP_CONFIG_CLOCK_FAST_CYC); // R2
	wire [5:0] halfW = {1'b0, periodW[5:1]};
	wire wrapW = (divCnt_ff >= periodW - 6'h01);
	wire riseEv = runClk && wrapW;
	wire fallEv = runClk && (divCnt_ff == halfW - 6'h01);

	always_ff @(posedge clk)
	begin
		if (srst || !runClk)
		begin
			divCnt_ff <= 6'h00;
			config_clock_ff <= 1'b0;
		end
		else
		begin
			divCnt_ff <= wrapW ? 6'h00 : divCnt_ff + 6'h01;
			if (riseEv)
				config_clock_ff <= 1'b1;
			else if (fallEv)
				config_clock_ff <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read clock and rom address for master parallel
	logic [2:0] rcnt_ff;
	logic [`FCP_ADDR_W-1:0] addr_ff;
	wire mpar = runClk && (mode_ff == fcp_pkg::MD_MPAR);
	wire romTake = mpar && riseEv && (rcnt_ff == `FCP_RCLK_LAST_LOW); // R12

	always_ff @(posedge clk)
	begin
		if (srst || !mpar)
		begin
			rcnt_ff <= 3'h0;
			addr_ff <= '0;
		end
		else if (riseEv)
		begin
			rcnt_ff <= rcnt_ff + 3'h1; // R3
			if (rcnt_ff == `FCP_RCLK_HIGH_CNT)
				addr_ff <= addr_ff + `FCP_ADDR_W'(1); // R12
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// asynchronous peripheral write accept and status read
	logic wrPrev_ff;
	logic ready_ff;
	wire aper = runClk && (mode_ff == fcp_pkg::MD_APER);
	wire selW = !pin_ff.selectLineAN && pin_ff.selectLineB;
	wire wrTake = aper && selW && ready_ff && !wrPrev_ff && pin_ff.writeN;

	////////////////////////////////////////////////////////////////////////////
	// byte shifter to the daisy chain, msb first
	logic [7:0] shift_ff;
	// rom byte waits here while the previous byte sends its last bit
	logic [7:0] hold_ff;
	logic [3:0] bitsLeft_ff;
	logic skip_ff;
	logic serBit_ff;
	logic serHave_ff;
	logic daisy_ff;
	logic bitV_ff;
	wire mser = runClk && (mode_ff == fcp_pkg::MD_MSER);
	wire shiftNow = fallEv && ((bitsLeft_ff != 4'h0) || skip_ff);

	always_ff @(posedge clk)
	begin
		if (srst || !runClk)
		begin
			wrPrev_ff <= 1'b1;
			ready_ff <= 1'b1;
			shift_ff <= 8'h00;
			hold_ff <= 8'h00;
			bitsLeft_ff <= 4'h0;
			skip_ff <= 1'b0;
			serBit_ff <= 1'b0;
			serHave_ff <= 1'b0;
			daisy_ff <= 1'b0;
			bitV_ff <= 1'b0;
		end
		else
		begin
			wrPrev_ff <= pin_ff.writeN;
			bitV_ff <= 1'b0;
			if (mser && riseEv)
			begin
				serBit_ff <= pin_ff.serialIn;
				serHave_ff <= 1'b1;
			end
			if (mser && fallEv && serHave_ff)
			begin
				daisy_ff <= serBit_ff; // R1
				bitV_ff <= 1'b1;
				serHave_ff <= 1'b0;
			end
			if (wrTake)
			begin
				shift_ff <= pin_ff.data; // R11
				bitsLeft_ff <= `FCP_BYTE_BITS;
				ready_ff <= 1'b0;
			end
			else if (romTake)
			begin
				hold_ff <= pin_ff.data; // R12
				skip_ff <= 1'b1; // R4
			end
			else if (shiftNow)
			begin
				if (bitsLeft_ff != 4'h0)
				begin
					daisy_ff <= shift_ff[7]; // R11
					bitV_ff <= 1'b1;
				end
				if (bitsLeft_ff == 4'h1)
					ready_ff <= 1'b1; // R5
				if (skip_ff)
				begin
					shift_ff <= hold_ff; // R4
					bitsLeft_ff <= `FCP_BYTE_BITS;
					skip_ff <= 1'b0;
				end
				else
				begin
					shift_ff <= {shift_ff[6:0], 1'b0};
					bitsLeft_ff <= bitsLeft_ff - 4'h1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs
	logic init_ff;
	logic d7Oe_ff;
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			init_ff <= 1'b0;
			d7Oe_ff <= 1'b0;
		end
		else
		begin
			init_ff <= (nxt_state == fcp_pkg::ST_LOAD); // R9
			d7Oe_ff <= aper && selW && !pin_ff.readN; // R7
		end
	end

	assign configClock = config_clock_ff;
	assign daisyOut = daisy_ff;
	assign readyOut = ready_ff; // R6
	assign dataBitSevenOut = ready_ff; // R6
	assign dataBitSevenOe = d7Oe_ff; // R7
	assign initDone = init_ff;
	assign romOut = '{readClock: (rcnt_ff == `FCP_RCLK_HIGH_CNT) && mpar, addr: addr_ff}; // R3
	assign cfgBit = daisy_ff;
	assign cfgBitValid = bitV_ff;

endmodule : fcp_config_port

// [hdl/fcp_regs.svh]
`ifndef FCP_REGS_SVH
`define FCP_REGS_SVH

// system clock period
`define FCP_CLK_NS 20
// nominal configuration clock periods for speed select low / high
`define FCP_CONFIG_CLOCK_FAST_NS 100
`define FCP_CONFIG_CLOCK_SLOW_NS 800
`define FCP_CONFIG_CLOCK_FAST_CYC ((`FCP_CONFIG_CLOCK_FAST_NS) / (`FCP_CLK_NS))
`define FCP_CONFIG_CLOCK_SLOW_CYC ((`FCP_CONFIG_CLOCK_SLOW_NS) / (`FCP_CLK_NS))
// clear latency after program release, least figure, rounded up
`define FCP_INIT_LAT_NS 63360
`define FCP_INIT_LAT_CYC (((`FCP_INIT_LAT_NS) + (`FCP_CLK_NS) - 1) / (`FCP_CLK_NS))
// read clock: low phase in configuration clocks, last count is the high one
`define FCP_RCLK_LOW_CCLKS 7
`define FCP_RCLK_HIGH_CNT 3'h7
`define FCP_RCLK_LAST_LOW 3'h6
`define FCP_ADDR_W 18
`define FCP_BYTE_BITS 4'h8

`endif

// [hdl/fcp_pkg.sv]
package fcp_pkg;

	typedef enum logic [1:0] {
		MD_MSER = 2'h0,
		MD_MPAR = 2'h1,
		MD_APER = 2'h2,
		MD_NONE = 2'h3
	} fcp_mode_t;

	// gray along hold -> clear -> load
	typedef enum logic [1:0] {
		ST_HOLD = 2'h0,
		ST_CLEAR = 2'h1,
		ST_LOAD = 2'h3
	} fcp_state_t;

	typedef struct packed {
		logic programRequestN;
		logic clockSpeedSelect;
		logic [1:0] modeSel;
		logic serialIn;
		logic writeN;
		logic selectLineAN;
		logic selectLineB;
		logic readN;
		logic [7:0] data;
	} fcp_pins_t;

	typedef struct packed {
		logic readClock;
		logic [17:0] addr;
	} fcp_rom_t;

endpackage : fcp_pkg

// [test/fcp_config_port_properties.sv]
`timescale 1ns/1ps
module fcp_config_port_properties (
	input wire logic clk,
	input wire logic srst,
	input wire fcp_pkg::fcp_pins_t pinsIn,
	input wire logic configClock,
	input wire logic daisyOut,
	input wire logic readyOut,
	input wire logic initDone,
	input wire fcp_pkg::fcp_rom_t romOut,
	input wire logic dataBitSevenOut,
	input wire logic dataBitSevenOe,
	input wire logic cfgBit,
	input wire logic cfgBitValid
);
	default clocking @(posedge clk); endclocking
	// a program request stops the clocks, so it ends every attempt
	default disable iff (srst || !pinsIn.programRequestN);
	sequence s_fast; configClock [*2] ##1 !configClock [*3] ##1 configClock; endsequence
	property p_fwd; cfgBitValid |-> daisyOut == cfgBit && !configClock; endproperty
	a_fwd: assert property (p_fwd) else $error("daisy bit");
	property p_clk; $rose(configClock) && !pinsIn.clockSpeedSelect |-> s_fast; endproperty
	a_clk: assert property (p_clk) else $error("clock period");
	property p_rclk; $rose(romOut.readClock) && !pinsIn.clockSpeedSelect |-> romOut.readClock [*5] ##1 !romOut.readClock;
	endproperty
	a_rclk: assert property (p_rclk) else $error("read clock");
	property p_addr; $changed(romOut.addr) |-> !romOut.readClock; endproperty
	a_addr: assert property (p_addr) else $error("address step");
	property p_rdy; dataBitSevenOe |-> dataBitSevenOut == readyOut && initDone; endproperty
	a_rdy: assert property (p_rdy) else $error("bit seven");
	property p_oe; (!pinsIn.readN && !pinsIn.selectLineAN && pinsIn.selectLineB) [*7] |-> dataBitSevenOe; endproperty
	a_oe: assert property (p_oe) else $error("status drive");
	property p_end; $rose(readyOut) |-> cfgBitValid; endproperty
	a_end: assert property (p_end) else $error("ready end");
	property p_busy; $fell(readyOut) |-> ##[1:400] readyOut; endproperty
	a_busy: assert property (p_busy) else $error("busy long");
endmodule : fcp_config_port_properties
bind fcp_config_port fcp_config_port_properties u_chk (
	.clk(clk),
	.srst(srst),
	.pinsIn(pinsIn),
	.configClock(configClock),
	.daisyOut(daisyOut),
	.readyOut(readyOut),
	.initDone(initDone),
	.romOut(romOut),
	.dataBitSevenOut(dataBitSevenOut),
	.dataBitSevenOe(dataBitSevenOe),
	.cfgBit(cfgBit),
	.cfgBitValid(cfgBitValid)
);

// [test/fcp_prom_model.sv]
`timescale 1ns/1ps
module fcp_prom_model (
	input wire logic configClock,
	input wire fcp_pkg::fcp_rom_t romOut,
	output logic serialBit,
	output logic [7:0] romData
);
	logic [2:0] idx_ff = 3'h0;
	assign romData = romOut.addr[7:0] ^ 8'h5A;
	assign serialBit = ~idx_ff[0] ^ idx_ff[2];
	// step only after the device's sampling edge
	always @(posedge configClock)
		idx_ff <= idx_ff + 3'h1;
endmodule : fcp_prom_model

// [test/fcp_config_port_tb.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin checkCount++; if ((a) !== (b)) begin errorCnt++; $display("[ERR] %0t mismatch %h", $time, a); end end
module fcp_config_port_tb;
	logic clk = 1'h0;
	logic srst = 1'h1;
	fcp_pkg::fcp_pins_t pd, pinsIn;
	fcp_pkg::fcp_rom_t romOut;
	logic configClock, daisyOut, readyOut, initDone, dataBitSevenOut, dataBitSevenOe, cfgBit, cfgBitValid, serialBit;
	logic [7:0] romData, b;
	int errorCnt = 0;
	int checkCount = 0;
	wire [3:0] mon = {romOut.readClock, initDone, readyOut, cfgBitValid};
	always #10 clk = ~clk;
	always_comb
	begin
		pinsIn = pd;
		pinsIn.serialIn = serialBit;
		if (pd.modeSel == fcp_pkg::MD_MPAR)
			pinsIn.data = romData;
	end
	fcp_config_port dut (
		.clk(clk),
		.srst(srst),
		.pinsIn(pinsIn),
		.configClock(configClock),
		.daisyOut(daisyOut),
		.readyOut(readyOut),
		.initDone(initDone),
		.romOut(romOut),
		.dataBitSevenOut(dataBitSevenOut),
		.dataBitSevenOe(dataBitSevenOe),
		.cfgBit(cfgBit),
		.cfgBitValid(cfgBitValid)
	);
	fcp_prom_model prom (
		.configClock(configClock),
		.romOut(romOut),
		.serialBit(serialBit),
		.romData(romData)
	);
	task automatic testDone;
		$display("checks %0d errors %0d", checkCount, errorCnt);
		if (errorCnt == 0 && checkCount > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : testDone
	task automatic tk(input int n);
		repeat (n) @(posedge clk) #2;
	endtask : tk
	task automatic waitHi(input int i);
		int k;
		for (k = 0; k < 9000 && mon[i] !== 1'h1; k++)
			tk(1);
		if (k == 9000)
		begin
			errorCnt++;
			testDone();
		end
	endtask : waitHi
	task automatic grab(input logic [7:0] e);
		repeat (8)
		begin
			waitHi(0);
			b = {b[6:0], cfgBit};
			tk(1);
		end
		`CHK(b, e)
	endtask : grab
	task automatic load(input logic [1:0] md, input logic spd);
		pd.programRequestN = 1'h0;
		pd.modeSel = md;
		pd.clockSpeedSelect = spd;
		tk(9);
		`CHK(initDone, 1'h0)
		pd.programRequestN = 1'h1;
		waitHi(2);
	endtask : load
	task automatic wr(input logic [7:0] v);
		pd.data = v;
		pd.writeN = 1'h0;
		tk(8);
		pd.writeN = 1'h1;
		tk(8);
	endtask : wr
	initial
	begin
		pd = '{1'h1, 1'h0, 2'h0, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1, 8'h00};
		tk(3);
		srst = 1'h0;
		grab(8'hA5);
		$display("serial end");
		load(fcp_pkg::MD_MPAR, 1'h0);
		waitHi(3);
		tk(6);
		`CHK(romOut.addr, 18'h0_0001)
		grab(8'h5A);
		grab(8'h5B);
		$display("parallel end");
		load(fcp_pkg::MD_APER, 1'h1);
		tk(80);
		fork
			grab(8'hC3);
			begin
				wr(8'hC3);
				wr(8'h3C);
				pd.readN = 1'h0;
				tk(8);
				`CHK({dataBitSevenOe, dataBitSevenOut}, 2'h2)
			end
		join
		waitHi(1);
		`CHK(dataBitSevenOut, 1'h1)
		pd.readN = 1'h1;
		fork
			grab(8'hA5);
			wr(8'hA5);
		join
		`CHK(dataBitSevenOe, 1'h0)
		$display("async end");
		testDone;
	end
endmodule : fcp_config_port_tb
